// ### design/fps_pkg.sv
// package: offsets, field layout, reset values and defaults of the flash protect and status block
package fps_pkg;

  // -------------------------------------------------------------------------
  // register map (4-bit byte offsets)
  // -------------------------------------------------------------------------
  localparam logic [3:0] ADDR_CONFIG = 4'h3;
  localparam logic [3:0] ADDR_PROT   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;

  // -------------------------------------------------------------------------
  // flash_config_reg fields
  // -------------------------------------------------------------------------
  localparam int CFG_BUFFER_EMPTY_IE = 7;
  localparam int CFG_COMPLETE_IE     = 6;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hC0;
  localparam logic [7:0] CFG_RESET      = 8'h00;

  // -------------------------------------------------------------------------
  // protection_config_reg fields
  // -------------------------------------------------------------------------
  localparam int PROT_POLARITY  = 7;
  localparam int PROT_NV6       = 6;
  localparam int PROT_HIGH_DIS  = 5;
  localparam int PROT_HIGH_SZ_H = 4;
  localparam int PROT_HIGH_SZ_L = 3;
  localparam int PROT_LOW_DIS   = 2;
  localparam int PROT_LOW_SZ_H  = 1;
  localparam int PROT_LOW_SZ_L  = 0;
  // reset value before the nonvolatile copy is loaded: no protection
  localparam logic [7:0] PROT_RESET = 8'hFF;

  // -------------------------------------------------------------------------
  // flash_status_reg fields
  // -------------------------------------------------------------------------
  localparam int ST_BUFFER_EMPTY = 7;
  localparam int ST_COMPLETE     = 6;
  localparam int ST_VIOLATION    = 5;
  localparam int ST_ACCESS_ERR   = 4;
  localparam int ST_BLANK        = 2;
  localparam int ST_FAIL         = 1;
  localparam int ST_DONE         = 0;

  // -------------------------------------------------------------------------
  // address windows
  // -------------------------------------------------------------------------
  localparam logic [15:0] HIGH_END   = 16'hFFFF;
  localparam logic [15:0] HIGH_BASE0 = 16'hF800;
  localparam logic [15:0] HIGH_BASE1 = 16'hF000;
  localparam logic [15:0] HIGH_BASE2 = 16'hE000;
  localparam logic [15:0] HIGH_BASE3 = 16'hC000;
  localparam logic [15:0] LOW_BASE   = 16'h4000;
  localparam logic [15:0] LOW_END0   = 16'h43FF;
  localparam logic [15:0] LOW_END1   = 16'h47FF;
  localparam logic [15:0] LOW_END2   = 16'h4FFF;
  localparam logic [15:0] LOW_END3   = 16'h5FFF;

  // -------------------------------------------------------------------------
  // scenario tables: index = {polarity, high_dis, low_dis}, 3 bits each entry
  // -------------------------------------------------------------------------
  localparam logic [23:0] SCEN_MAP_DEFAULT = 24'hFAC_688;
  // row r (from-scenario) occupies bits [8r+7:8r], bit t set = r->t allowed
  localparam logic [63:0] ALLOW_DEFAULT = 64'hFF5A_3C18_080C_0A0F;

endpackage

// ### design/fps_range_decode.sv
// file: window hit decoder for the high and low protection ranges
`timescale 1ns/1ps
module fps_range_decode
  import fps_pkg::*;
(
  input  wire logic [15:0] addr,
  input  wire logic [1:0]  high_size,
  input  wire logic [1:0]  low_size,
  output logic             in_high,
  output logic             in_low
);

  logic [15:0] high_base;
  logic [15:0] low_end;

  always_comb
  begin
    case (high_size)
      2'b00:   high_base = HIGH_BASE0;
      2'b01:   high_base = HIGH_BASE1;
      2'b10:   high_base = HIGH_BASE2;
      default: high_base = HIGH_BASE3;
    endcase
    case (low_size)
      2'b00:   low_end = LOW_END0;
      2'b01:   low_end = LOW_END1;
      2'b10:   low_end = LOW_END2;
      default: low_end = LOW_END3;
    endcase
  end

  assign in_high = (addr >= high_base) && (addr <= HIGH_END);
  assign in_low  = (addr >= LOW_BASE) && (addr <= low_end);

endmodule

// ### design/fps_scenario.sv
// file: protection scenario lookup and transition permission table
`timescale 1ns/1ps
module fps_scenario
  import fps_pkg::*;
#(
  parameter logic [23:0] SCEN_MAP = SCEN_MAP_DEFAULT,
  parameter logic [63:0] ALLOW    = ALLOW_DEFAULT
)
(
  input  wire logic [2:0] cur_bits,
  input  wire logic [2:0] new_bits,
  output logic [2:0]      cur_scen,
  output logic            allowed
);

  logic [2:0] new_scen;

  function automatic logic [2:0] scen_of(input logic [2:0] bits);
    scen_of = SCEN_MAP[bits*3 +: 3];
  endfunction

  assign cur_scen = scen_of(cur_bits);
  assign new_scen = scen_of(new_bits);
  assign allowed  = ALLOW[{cur_scen, new_scen}];

endmodule

// ### design/fps_flash_protect.sv
// file: top of the flash protection and command status block
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module fps_flash_protect
  import fps_pkg::*;
#(
  parameter logic [23:0] SCEN_MAP = SCEN_MAP_DEFAULT,
  parameter logic [63:0] ALLOW    = ALLOW_DEFAULT
)
(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [3:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [7:0]       RDATA,
  input  wire logic [7:0]  NV_PROT_VALUE,
  input  wire logic        SPECIAL_MODE,
  input  wire logic        WORD_WRITE,
  input  wire logic [15:0] WORD_ADDR,
  input  wire logic        WORD_IS_PROG_ERASE,
  input  wire logic        BUFFER_FETCH,
  input  wire logic        ENGINE_IDLE,
  input  wire logic        OP_ACTIVE,
  input  wire logic        FAIL_SET,
  input  wire logic        BLANK_SET,
  output logic             CMD_LAUNCH,
  output logic [15:0]      CMD_ADDR,
  output logic             IRQ
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  logic [7:0]  prot;
  logic        nv_loaded;
  logic [7:0]  cfg;
  logic        buffer_empty;
  logic        complete;
  logic        violation;
  logic        access_err;
  logic        blank;
  logic        fail;
  logic        seq_active;
  logic        seq_prog_erase;
  logic [15:0] seq_addr;
  logic        special_meta;
  logic        special;

  // -------------------------------------------------------------------------
  // decoded accesses
  // -------------------------------------------------------------------------
  logic       wr_cfg;
  logic       wr_prot;
  logic       wr_status;
  logic [7:0] next_prot;
  logic [2:0] cur_scen;
  logic       prot_allowed;
  logic       in_high;
  logic       in_low;
  logic       range_hit;
  logic       addr_protected;
  logic       launch_req;
  logic       launch_blocked;
  logic       launch_ok;
  logic       abort_zero;
  logic [7:0] status_view;
  logic [7:0] next_rdata;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] offs);
    hit = (a == offs);
  endfunction

  assign wr_cfg    = WR && hit(ADDR, ADDR_CONFIG);
  assign wr_prot   = WR && hit(ADDR, ADDR_PROT) && nv_loaded;
  assign wr_status = WR && hit(ADDR, ADDR_STATUS);

  // -------------------------------------------------------------------------
  // mode pin synchroniser
  // -------------------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      special_meta <= 1'b0;
      special      <= 1'b0;
    end
    else
    begin
      special_meta <= SPECIAL_MODE;
      special      <= special_meta;
    end
  end

  // -------------------------------------------------------------------------
  // protection configuration
  // -------------------------------------------------------------------------
  // size fields only follow the write while the matching disable bit is
  // already set in the stored value; otherwise the old size is kept
  always_comb
  begin
    next_prot                 = prot;
    next_prot[PROT_POLARITY]  = WDATA[PROT_POLARITY];
    next_prot[PROT_HIGH_DIS]  = WDATA[PROT_HIGH_DIS];
    next_prot[PROT_LOW_DIS]   = WDATA[PROT_LOW_DIS];
    if (prot[PROT_HIGH_DIS])
    begin
      next_prot[PROT_HIGH_SZ_H:PROT_HIGH_SZ_L] = WDATA[PROT_HIGH_SZ_H:PROT_HIGH_SZ_L];
    end
    if (prot[PROT_LOW_DIS])
    begin
      next_prot[PROT_LOW_SZ_H:PROT_LOW_SZ_L] = WDATA[PROT_LOW_SZ_H:PROT_LOW_SZ_L];
    end
  end

  fps_scenario #(
    .SCEN_MAP (SCEN_MAP),
    .ALLOW    (ALLOW)
  ) u_scenario (
    .cur_bits ({prot[PROT_POLARITY], prot[PROT_HIGH_DIS], prot[PROT_LOW_DIS]}),
    .new_bits ({next_prot[PROT_POLARITY], next_prot[PROT_HIGH_DIS], next_prot[PROT_LOW_DIS]}),
    .cur_scen (cur_scen),
    .allowed  (prot_allowed)
  );

  // nonvolatile copy is taken at the first edge after reset release, so the
  // asynchronous reset itself only ever loads a constant
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      nv_loaded <= 1'b0;
      prot      <= PROT_RESET;
    end
    else if (!nv_loaded)
    begin
      nv_loaded <= 1'b1;
      prot      <= NV_PROT_VALUE;
    end
    else if (wr_prot && prot_allowed)
    begin
      prot <= next_prot;
    end
    // a refused write leaves prot untouched
  end

  // -------------------------------------------------------------------------
  // protected address check
  // -------------------------------------------------------------------------
  fps_range_decode u_range (
    .addr      (seq_addr),
    .high_size (prot[PROT_HIGH_SZ_H:PROT_HIGH_SZ_L]),
    .low_size  (prot[PROT_LOW_SZ_H:PROT_LOW_SZ_L]),
    .in_high   (in_high),
    .in_low    (in_low)
  );

  assign range_hit = (!prot[PROT_HIGH_DIS] && in_high) || (!prot[PROT_LOW_DIS] && in_low);
  // open polarity protects the enabled ranges, closed protects the rest
  assign addr_protected = prot[PROT_POLARITY] ? range_hit : !range_hit;

  // -------------------------------------------------------------------------
  // command write sequence
  // -------------------------------------------------------------------------
  assign launch_req     = wr_status && WDATA[ST_BUFFER_EMPTY] && seq_active && buffer_empty;
  // any pending error flag, or fail in special modes, stops the launch
  assign launch_blocked = violation || access_err || (special && fail);
  assign launch_ok      = launch_req && !launch_blocked
                          && !(seq_prog_erase && addr_protected);
  assign abort_zero     = wr_status && !WDATA[ST_BUFFER_EMPTY] && seq_active;

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      seq_active     <= 1'b0;
      seq_prog_erase <= 1'b0;
      seq_addr       <= 16'h0000;
    end
    else if (launch_req || abort_zero)
    begin
      seq_active <= 1'b0;
    end
    else if (WORD_WRITE && buffer_empty && !seq_active)
    begin
      seq_active     <= 1'b1;
      seq_prog_erase <= WORD_IS_PROG_ERASE;
      seq_addr       <= WORD_ADDR;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      CMD_LAUNCH <= 1'b0;
      CMD_ADDR   <= 16'h0000;
    end
    else
    begin
      CMD_LAUNCH <= launch_ok;
      if (launch_ok)
      begin
        CMD_ADDR <= seq_addr;
      end
    end
  end

  // -------------------------------------------------------------------------
  // status flags
  // -------------------------------------------------------------------------
  // buffer refill from the engine wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      buffer_empty <= 1'b1;
    end
    else if (BUFFER_FETCH)
    begin
      buffer_empty <= 1'b1;
    end
    else if (launch_ok)
    begin
      buffer_empty <= 1'b0;
    end
  end

  // complete only rises when the engine reports idle with nothing pending;
  // a fetch of a pending command keeps ENGINE_IDLE low
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      complete <= 1'b1;
    end
    else if (!buffer_empty || launch_ok)
    begin
      complete <= 1'b0;
    end
    else if (ENGINE_IDLE)
    begin
      complete <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      violation <= 1'b0;
    end
    else if (launch_req && !launch_blocked && seq_prog_erase && addr_protected)
    begin
      violation <= 1'b1;
    end
    else if (wr_status && WDATA[ST_VIOLATION])
    begin
      violation <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      access_err <= 1'b0;
    end
    else if (abort_zero)
    begin
      access_err <= 1'b1;
    end
    else if (wr_status && WDATA[ST_ACCESS_ERR])
    begin
      access_err <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      fail <= 1'b0;
    end
    else if (FAIL_SET && special)
    begin
      fail <= 1'b1;
    end
    else if (wr_status && special && WDATA[ST_FAIL])
    begin
      fail <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      blank <= 1'b0;
    end
    else if (BLANK_SET)
    begin
      blank <= 1'b1;
    end
    else if (launch_ok)
    begin
      blank <= 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // configuration register and interrupt request
  // -------------------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cfg <= CFG_RESET;
    end
    else if (wr_cfg)
    begin
      cfg <= WDATA & CFG_WRITE_MASK;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      IRQ <= 1'b0;
    end
    else
    begin
      IRQ <= (buffer_empty && cfg[CFG_BUFFER_EMPTY_IE])
             || (complete && cfg[CFG_COMPLETE_IE]);
    end
  end

  // -------------------------------------------------------------------------
  // read path
  // -------------------------------------------------------------------------
  // fail and done are hidden outside special modes
  always_comb
  begin
    status_view                  = 8'h00;
    status_view[ST_BUFFER_EMPTY] = buffer_empty;
    status_view[ST_COMPLETE]     = complete;
    status_view[ST_VIOLATION]    = violation;
    status_view[ST_ACCESS_ERR]   = access_err;
    status_view[ST_BLANK]        = blank;
    status_view[ST_FAIL]         = special && fail;
    status_view[ST_DONE]         = special && !OP_ACTIVE;
  end

  always_comb
  begin
    if (hit(ADDR, ADDR_CONFIG))
    begin
      next_rdata = cfg;
    end
    else if (hit(ADDR, ADDR_PROT))
    begin
      next_rdata = prot;
    end
    else if (hit(ADDR, ADDR_STATUS))
    begin
      next_rdata = status_view;
    end
    else
    begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      RDATA <= 8'h00;
    end
    else if (RD)
    begin
      RDATA <= next_rdata;
    end
    else
    begin
      RDATA <= 8'h00;
    end
  end

  // cur_scen is exposed for debug visibility through hierarchy only
  logic [2:0] active_scen;
  assign active_scen = cur_scen;

endmodule

// ### tb/fps_flash_protect_checker.sv
// checker: port-level assertions for the flash protect and status block
`timescale 1ns/1ps
module fps_flash_protect_checker
  import fps_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [3:0]  ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  input  wire logic [7:0]  RDATA,
  input  wire logic        SPECIAL_MODE,
  input  wire logic        WORD_WRITE,
  input  wire logic [15:0] WORD_ADDR,
  input  wire logic        CMD_LAUNCH,
  input  wire logic [15:0] CMD_ADDR,
  input  wire logic        IRQ
);
  // ---------------------------------------------------------------
  // shadow state
  // ---------------------------------------------------------------
  logic [7:0]  cfg_sh;
  logic [15:0] last_word;
  logic [1:0]  norm_cnt;
  logic        launch_req;

  assign launch_req = WR && ADDR == ADDR_STATUS && WDATA[7];

  // norm_cnt saturates once the mode synchroniser has surely settled to normal
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cfg_sh    <= 8'h00;
      last_word <= 16'h0000;
      norm_cnt  <= 2'h0;
    end
    else
    begin
      if (WR && ADDR == ADDR_CONFIG) cfg_sh <= WDATA & CFG_WRITE_MASK;
      if (WORD_WRITE) last_word <= WORD_ADDR;
      norm_cnt <= SPECIAL_MODE ? 2'h0 : (norm_cnt == 2'h3 ? 2'h3 : norm_cnt + 2'h1);
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);

  property p_rdata_idle;
    !RD |=> RDATA == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero off read");

  property p_status_zero;
    (RD && ADDR == ADDR_STATUS && norm_cnt == 2'h3) |=> RDATA[3] == 1'b0 && RDATA[1:0] == 2'h0;
  endproperty
  a_status_zero: assert property (p_status_zero) else $error("status low bits set in normal");

  property p_cfg_read;
    (RD && ADDR == ADDR_CONFIG) |=> RDATA == cfg_sh;
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");

  property p_irq_off;
    (cfg_sh == 8'h00) |=> !IRQ;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq with enables off");

  property p_launch_cause;
    CMD_LAUNCH |-> $past(launch_req);
  endproperty
  a_launch_cause: assert property (p_launch_cause) else $error("launch without bit7 write");

  property p_launch_addr;
    CMD_LAUNCH |-> CMD_ADDR == last_word;
  endproperty
  a_launch_addr: assert property (p_launch_addr) else $error("launch address wrong");

  property p_addr_hold;
    !CMD_LAUNCH |-> $stable(CMD_ADDR);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("command address moved");

  property p_launch_gap;
    CMD_LAUNCH |=> !CMD_LAUNCH [*2];
  endproperty
  a_launch_gap: assert property (p_launch_gap) else $error("launch too soon");

  c_launch: cover property (CMD_LAUNCH);
  c_irq: cover property (IRQ);
  c_refused: cover property (launch_req ##1 !CMD_LAUNCH);
endmodule

// ### tb/fps_flash_protect_tb_top.sv
// testbench: register, protection and command sequence tests
`timescale 1ns/1ps
module fps_flash_protect_tb_top
  import fps_pkg::*;
;
  logic        CLK = 1'b0;
  logic        NRST = 1'b0;
  logic        WR = 1'b0, RD = 1'b0, WORD_WRITE = 1'b0, WORD_IS_PROG_ERASE = 1'b0;
  logic        BUFFER_FETCH = 1'b0, ENGINE_IDLE = 1'b1, OP_ACTIVE = 1'b0;
  logic        SPECIAL_MODE = 1'b0, FAIL_SET = 1'b0, BLANK_SET = 1'b0;
  logic        CMD_LAUNCH, IRQ;
  logic [3:0]  ADDR = 4'h0;
  logic [7:0]  WDATA = 8'h00, NV_PROT_VALUE = 8'hFF, RDATA;
  logic [15:0] WORD_ADDR = 16'h0000, CMD_ADDR;
  int          fail_count = 0, checks = 0;

  // scenario to {polarity, high disable, low disable}, and permitted targets per row
  // scenario 1 keeps the low range protected and 2 the high one, so that
  // the moves 6->1 and 5->2 only add protection
  localparam logic [2:0]  IDX [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  localparam logic [7:0]  OK_TO [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
  localparam logic [15:0] HB [4] = '{16'hF800, 16'hF000, 16'hE000, 16'hC000};
  localparam logic [15:0] LE [4] = '{16'h43FF, 16'h47FF, 16'h4FFF, 16'h5FFF};

  always #2.5 CLK = ~CLK;

  fps_flash_protect i_fps_flash_protect (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .NV_PROT_VALUE(NV_PROT_VALUE), .SPECIAL_MODE(SPECIAL_MODE),
    .WORD_WRITE(WORD_WRITE), .WORD_ADDR(WORD_ADDR), .WORD_IS_PROG_ERASE(WORD_IS_PROG_ERASE),
    .BUFFER_FETCH(BUFFER_FETCH), .ENGINE_IDLE(ENGINE_IDLE), .OP_ACTIVE(OP_ACTIVE),
    .FAIL_SET(FAIL_SET), .BLANK_SET(BLANK_SET), .CMD_LAUNCH(CMD_LAUNCH), .CMD_ADDR(CMD_ADDR),
    .IRQ(IRQ));

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  function automatic logic [7:0] pbyte(input int s);
    return {IDX[s][2], 1'h1, IDX[s][1], 2'h3, IDX[s][0], 2'h3};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic do_reset(input logic [7:0] nv);
    @(posedge CLK);
    NRST          <= 1'b0;
    NV_PROT_VALUE <= nv;
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    repeat (2) @(posedge CLK);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  // read data are looked at only in the cycle right after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    chk(RDATA, exp);
  endtask

  task automatic word(input logic [15:0] a);
    @(posedge CLK);
    WORD_WRITE         <= 1'b1;
    WORD_ADDR          <= a;
    WORD_IS_PROG_ERASE <= 1'b1;
    @(posedge CLK);
    WORD_WRITE <= 1'b0;
  endtask

  task automatic fetch();
    @(posedge CLK);
    BUFFER_FETCH <= 1'b1;
    @(posedge CLK);
    BUFFER_FETCH <= 1'b0;
  endtask

  // refused attempts leave flags behind, so they are cleared before the next one
  task automatic launch(input logic [15:0] a, input logic ok, input logic [7:0] st);
    word(a);
    wr(ADDR_STATUS, 8'h80);
    #1;
    chk(CMD_LAUNCH, ok);
    if (ok)
      chk(CMD_ADDR, a);
    rd(ADDR_STATUS, st);
    if (ok)
      fetch();
    else
      wr(ADDR_STATUS, 8'h30);
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    summarize();
  end

  initial
  begin
    for (int f = 0; f < 8; f++)
      for (int t = 0; t < 8; t++)
      begin
        do_reset(pbyte(f));
        wr(ADDR_PROT, pbyte(t));
        rd(ADDR_PROT, OK_TO[f][t] ? pbyte(t) : pbyte(f));
      end
    do_reset(8'hDB);
    rd(ADDR_PROT, 8'hDB);
    wr(ADDR_PROT, 8'hC3);
    rd(ADDR_PROT, 8'hDB);
    do_reset(8'hFF);
    wr(ADDR_PROT, 8'hE4);
    rd(ADDR_PROT, 8'hE4);
    $display("test transitions done");
    for (int k = 0; k < 4; k++)
    begin
      do_reset({3'h6, k[1:0], 1'h0, k[1:0]});
      launch(HB[k] - 16'h0002, 1'b1, 8'h00);
      launch(HB[k], 1'b0, 8'hE0);
      launch(LE[k] - 16'h0001, 1'b0, 8'hE0);
      launch(LE[k] + 16'h0001, 1'b1, 8'h00);
    end
    do_reset(pbyte(0));
    launch(16'hC000, 1'b1, 8'h00);
    launch(16'hBFFE, 1'b0, 8'hE0);
    launch(16'h4000, 1'b1, 8'h00);
    launch(16'h3FFE, 1'b0, 8'hE0);
    do_reset(pbyte(3));
    launch(16'h8000, 1'b0, 8'hE0);
    do_reset(pbyte(7));
    launch(16'hC000, 1'b1, 8'h00);
    $display("test ranges done");
    word(16'h8000);
    wr(ADDR_STATUS, 8'h00);
    rd(ADDR_STATUS, 8'hD0);
    wr(ADDR_STATUS, 8'h10);
    wr(ADDR_STATUS, 8'h40);
    rd(ADDR_STATUS, 8'hC0);
    wr(ADDR_CONFIG, 8'h40);
    rd(ADDR_CONFIG, 8'h40);
    chk(IRQ, 1'b1);
    @(posedge CLK) ENGINE_IDLE <= 1'b0;
    launch(16'h8000, 1'b1, 8'h00);
    rd(ADDR_STATUS, 8'h80);
    chk(IRQ, 1'b0);
    @(posedge CLK) ENGINE_IDLE <= 1'b1;
    rd(ADDR_STATUS, 8'hC0);
    chk(IRQ, 1'b1);
    wr(ADDR_CONFIG, 8'h80);
    rd(ADDR_CONFIG, 8'h80);
    chk(IRQ, 1'b1);
    wr(ADDR_CONFIG, 8'h3F);
    rd(ADDR_CONFIG, 8'h00);
    chk(IRQ, 1'b0);
    $display("test status done");
    @(posedge CLK) SPECIAL_MODE <= 1'b1;
    repeat (3) @(posedge CLK);
    FAIL_SET <= 1'b1;
    @(posedge CLK) FAIL_SET <= 1'b0;
    rd(ADDR_STATUS, 8'hC3);
    wr(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, 8'hC3);
    launch(16'h8000, 1'b0, 8'hC3);
    wr(ADDR_STATUS, 8'h02);
    @(posedge CLK) OP_ACTIVE <= 1'b1;
    rd(ADDR_STATUS, 8'hC0);
    @(posedge CLK);
    OP_ACTIVE    <= 1'b0;
    SPECIAL_MODE <= 1'b0;
    repeat (3) @(posedge CLK);
    FAIL_SET  <= 1'b1;
    BLANK_SET <= 1'b1;
    @(posedge CLK);
    FAIL_SET  <= 1'b0;
    BLANK_SET <= 1'b0;
    rd(ADDR_STATUS, 8'hC4);
    wr(ADDR_STATUS, 8'h04);
    rd(ADDR_STATUS, 8'hC4);
    $display("test modes done");
    summarize();
  end
endmodule

bind fps_flash_protect fps_flash_protect_checker i_fps_flash_protect_checker (.CLK(CLK),
  .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .SPECIAL_MODE(SPECIAL_MODE), .WORD_WRITE(WORD_WRITE), .WORD_ADDR(WORD_ADDR),
  .CMD_LAUNCH(CMD_LAUNCH), .CMD_ADDR(CMD_ADDR), .IRQ(IRQ));
